// ===== pkg/tx_payload_pkg.sv
package tx_payload_pkg;

    // =========================================================
    // register indices (printed offsets), byte address = 4*index
    // =========================================================
    localparam logic [11:0] IDX_TEST_CFG = 12'h0_0c7;
    localparam logic [11:0] IDX_ACC_STATUS = 12'h0_0c8;
    localparam logic [11:0] IDX_ACC_CONTROL = 12'h0_0c9;
    localparam logic [11:0] IDX_ACC_DATA = 12'h0_0ca;
    localparam logic [11:0] IDX_PAYLOAD_CFG = 12'h0_0cb;
    localparam logic [11:0] IDX_FUNC_ENABLE = 12'h0_0cc;
    localparam int ADDR_SHIFT = 2;

    // =========================================================
    // reset values
    // =========================================================
    localparam logic [7:0] RST_TEST_CFG = 8'h00;
    localparam logic [7:0] RST_ACC_CONTROL = 8'h00;
    localparam logic [7:0] RST_ACC_DATA = 8'h00;
    localparam logic [7:0] RST_PAYLOAD_CFG = 8'h80;
    localparam logic [7:0] RST_FUNC_ENABLE = 8'h00;

    // =========================================================
    // field positions
    // =========================================================
    localparam int TC_LAUNCH_BIT = 0;
    localparam int TC_DIR_BIT = 1;
    localparam int TC_MODE_LSB = 2;
    localparam logic [7:0] TC_WRITE_MASK = 8'h0f;
    localparam int ST_BUSY_BIT = 0;
    localparam int AC_DIR_BIT = 7;
    localparam int PC_SNAP_BIT = 7;
    localparam int PC_GTRK_BIT = 6;
    localparam logic [7:0] PC_WRITE_MASK = 8'hc7;
    localparam int FE_ENABLE_BIT = 0;
    localparam int ENT_SUBST_LSB = 5;
    localparam int ENT_TEST_BIT = 6;
    localparam int ENT_STRK_BIT = 4;

    // =========================================================
    // indirect map
    // =========================================================
    localparam logic [6:0] IND_TRUNK_BASE = 7'h20;
    localparam logic [6:0] IND_SIG_BASE = 7'h40;
    localparam logic [6:0] IND_SIG_HOLE_A = 7'h40;
    localparam logic [6:0] IND_SIG_HOLE_B = 7'h50;
    localparam logic [6:0] IND_LAST = 7'h5f;

    // =========================================================
    // substitution and pattern modes
    // =========================================================
    typedef enum logic [2:0] {
        SUB_NONE = 3'b000,
        SUB_TRUNK = 3'b001,
        SUB_ALAW = 3'b010,
        SUB_ULAW = 3'b011,
        SUB_LOOP = 3'b100
    } subst_e;

    typedef enum logic [1:0] {
        PM_UNFRAMED = 2'b00,
        PM_BYTE = 2'b01,
        PM_SEVEN = 2'b10,
        PM_RSVD = 2'b11
    } pmode_e;

    // milliwatt sequences, eight bytes, index 0 in low byte
    localparam logic [63:0] ALAW_MW = 64'hb4a1_a1b4_3421_2134;
    localparam logic [63:0] ULAW_MW = 64'h9e8b_8b9e_1e0b_0b1e;
    localparam logic [7:0] SEVEN_MASK = 8'hfe;

    localparam int ACCESS_CYCLES = 2;

endpackage

// ===== src/e1_tx_payload_control_access.sv
`timescale 1ns/10ps
// Contract
// - busy flag shows ongoing indirect access
// - direction bit: 0 write, 1 read
// - indirect addresses 00-3F, 41-4F, 51-5F only
// - read command returns byte in data register
// - snapshot locks first-frame signaling per multiframe
// - global trunk off: per-slot signaling trunk bit
// - global trunk on: ABCD from entries everywhere
// - code 000: per-slot substitution field
// - code 001: per-slot data trunk code
// - codes 010/011: A-law/mu-law milliwatt
// - code 100: receive loopback; others reserved
// - test mode 00: all 32 slots
// - test mode 01: slots with test bit
// - test mode 10: seven MSBs only; 11 reserved
// - direction bit picks generate/check path
// - pattern engine starts on launch rising edge
// - enable bit gates all payload functions
module e1_tx_payload_control_access
    import tx_payload_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int ACC_CYCLES = ACCESS_CYCLES
) (
    input wire logic clk_sys_in, // 10 MHz system clock
    input wire logic rstn_in, // async reset, low
    // apb slave
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // 1 write
    input wire logic [ADDR_W-1:0] paddr, // byte address
    input wire logic [31:0] pwdata, // write data
    output logic [31:0] prdata, // read data
    output logic pready, // always ready
    output logic pslverr, // unmapped address
    // transmit stream in, one slot per valid
    input wire logic slot_valid_in, // slot strobe
    input wire logic [4:0] slot_num_in, // timeslot 0..31
    input wire logic [3:0] frame_num_in, // frame in multiframe
    input wire logic mf_gen_in, // signaling multiframe active
    input wire logic [7:0] tx_data_in, // slot payload
    input wire logic [3:0] tx_signaling_in, // slot ABCD
    input wire logic [7:0] lb_data_in, // receive elastic data
    input wire logic [7:0] prbs_data_in, // generator byte
    // transmit stream out
    output logic slot_valid_out, // slot strobe, 1 later
    output logic [4:0] slot_num_out, // timeslot
    output logic [7:0] tx_data_out, // processed payload
    output logic [3:0] tx_signaling_out, // processed ABCD
    // pattern engine control
    output logic pattern_start_out, // one-cycle start pulse
    output logic pattern_direction_out, // 0 gen tx, 1 gen rx
    output logic [1:0] pattern_framing_mode_out, // mode
    output logic [7:0] prbs_extract_mask_out, // bits for detector
    output logic prbs_extract_valid_out // tx byte to detector
);

    // =========================================================
    // registers
    // =========================================================
    logic [7:0] test_cfg_r;
    logic [7:0] acc_ctrl_r;
    logic [7:0] acc_data_r;
    logic [7:0] payload_cfg_r;
    logic [7:0] func_en_r;
    logic busy_r;
    logic [3:0] acc_cnt_r;
    logic launch_d_r;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_WAIT = 2'b01,
        ACC_DONE = 2'b10
    } acc_state_e;
    acc_state_e acc_state_r;
    acc_state_e acc_state_nxt;

    // =========================================================
    // apb decode
    // =========================================================
    logic [ADDR_W-1:0] a_test;
    logic [ADDR_W-1:0] a_stat;
    logic [ADDR_W-1:0] a_ctrl;
    logic [ADDR_W-1:0] a_data;
    logic [ADDR_W-1:0] a_pcfg;
    logic [ADDR_W-1:0] a_fen;
    assign a_test = ADDR_W'(IDX_TEST_CFG << ADDR_SHIFT);
    assign a_stat = ADDR_W'(IDX_ACC_STATUS << ADDR_SHIFT);
    assign a_ctrl = ADDR_W'(IDX_ACC_CONTROL << ADDR_SHIFT);
    assign a_data = ADDR_W'(IDX_ACC_DATA << ADDR_SHIFT);
    assign a_pcfg = ADDR_W'(IDX_PAYLOAD_CFG << ADDR_SHIFT);
    assign a_fen = ADDR_W'(IDX_FUNC_ENABLE << ADDR_SHIFT);

    logic acc;
    logic wr;
    logic hit;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign hit = (paddr == a_test) || (paddr == a_stat) ||
                 (paddr == a_ctrl) || (paddr == a_data) ||
                 (paddr == a_pcfg) || (paddr == a_fen);
    assign pready = 1'b1;
    assign pslverr = acc && !hit;

    logic ctrl_wr;
    assign ctrl_wr = wr && (paddr == a_ctrl);

    always_comb begin
        prdata = 32'h0000_0000;
        if (acc && !pwrite) begin
            case (paddr)
                a_test: prdata[7:0] = test_cfg_r;
                a_stat: prdata[ST_BUSY_BIT] = busy_r;
                a_ctrl: prdata[7:0] = acc_ctrl_r;
                a_data: prdata[7:0] = acc_data_r;
                a_pcfg: prdata[7:0] = payload_cfg_r;
                a_fen: prdata[7:0] = func_en_r;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            test_cfg_r <= RST_TEST_CFG;
            payload_cfg_r <= RST_PAYLOAD_CFG;
            func_en_r <= RST_FUNC_ENABLE;
        end else if (wr) begin
            if (paddr == a_test) begin
                test_cfg_r <= pwdata[7:0] & TC_WRITE_MASK;
            end
            if (paddr == a_pcfg) begin
                payload_cfg_r <= pwdata[7:0] & PC_WRITE_MASK;
            end
            if (paddr == a_fen) begin
                func_en_r <= {7'h00, pwdata[FE_ENABLE_BIT]};
            end
        end
    end

    // =========================================================
    // indirect access engine
    // =========================================================
    logic store_wr;
    logic [7:0] store_rdata;
    logic [7:0] subst_ent;
    logic [7:0] trunk_ent;
    logic [7:0] sig_ent;

    // a write command while busy is dropped, ctrl stays intact
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_ctrl_r <= RST_ACC_CONTROL;
        end else if (ctrl_wr && !busy_r) begin
            acc_ctrl_r <= pwdata[7:0];
        end
    end

    always_comb begin
        acc_state_nxt = acc_state_r;
        case (acc_state_r)
            ACC_IDLE: begin
                if (ctrl_wr) begin
                    acc_state_nxt = ACC_WAIT;
                end
            end
            ACC_WAIT: begin
                if (acc_cnt_r == 4'd0) begin
                    acc_state_nxt = ACC_DONE;
                end
            end
            ACC_DONE: acc_state_nxt = ACC_IDLE;
            default: acc_state_nxt = ACC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_state_r <= ACC_IDLE;
            busy_r <= 1'b0;
            acc_cnt_r <= 4'd0;
        end else begin
            acc_state_r <= acc_state_nxt;
            busy_r <= (acc_state_nxt != ACC_IDLE);
            if (acc_state_r == ACC_IDLE) begin
                acc_cnt_r <= 4'(ACC_CYCLES - 1);
            end else if (acc_cnt_r != 4'd0) begin
                acc_cnt_r <= acc_cnt_r - 4'd1;
            end
        end
    end

    // data register: host writes only while idle, read result lands
    // at the done cycle and overrides any same-cycle host write
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_data_r <= RST_ACC_DATA;
        end else if (acc_state_r == ACC_DONE &&
                     acc_ctrl_r[AC_DIR_BIT]) begin
            acc_data_r <= store_rdata;
        end else if (wr && paddr == a_data && !busy_r) begin
            acc_data_r <= pwdata[7:0];
        end
    end

    assign store_wr = (acc_state_r == ACC_DONE) &&
                      !acc_ctrl_r[AC_DIR_BIT];

    indirect_store #(
        .DEPTH(128)
    ) u_store (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .wr_en_in(store_wr),
        .addr_in(acc_ctrl_r[6:0]),
        .wdata_in(acc_data_r),
        .rdata_out(store_rdata),
        .slot_in(slot_num_in),
        .subst_ent_out(subst_ent),
        .trunk_ent_out(trunk_ent),
        .sig_ent_out(sig_ent)
    );

    // =========================================================
    // pattern engine control
    // =========================================================
    logic func_en;
    logic [1:0] pmode;
    logic pdir;
    assign func_en = func_en_r[FE_ENABLE_BIT];
    assign pmode = test_cfg_r[TC_MODE_LSB +: 2];
    assign pdir = test_cfg_r[TC_DIR_BIT];

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            launch_d_r <= 1'b0;
            pattern_start_out <= 1'b0;
        end else begin
            launch_d_r <= test_cfg_r[TC_LAUNCH_BIT];
            pattern_start_out <= func_en &&
                test_cfg_r[TC_LAUNCH_BIT] && !launch_d_r;
        end
    end
    assign pattern_direction_out = pdir;
    assign pattern_framing_mode_out = pmode;

    // per-slot mask of bits that the pattern touches
    logic [7:0] pmask;
    always_comb begin
        case (pmode)
            PM_UNFRAMED: pmask = 8'hff;
            PM_BYTE: pmask = sig_ent[ENT_TEST_BIT] ?
                             8'hff : 8'h00;
            PM_SEVEN: pmask = sig_ent[ENT_TEST_BIT] ?
                              SEVEN_MASK : 8'h00;
            default: pmask = 8'h00;
        endcase
    end

    // =========================================================
    // payload substitution
    // =========================================================
    logic [2:0] gsub;
    logic [2:0] eff_sub;
    logic [2:0] mw_idx;
    logic [7:0] sub_data;
    assign gsub = payload_cfg_r[2:0];
    assign mw_idx = frame_num_in[2:0];
    // per-slot code used only while global code is 000
    assign eff_sub = (gsub == SUB_NONE) ?
                     subst_ent[ENT_SUBST_LSB +: 3] : gsub;

    always_comb begin
        case (eff_sub)
            SUB_TRUNK: sub_data = trunk_ent;
            SUB_ALAW: sub_data = ALAW_MW[mw_idx*8 +: 8];
            SUB_ULAW: sub_data = ULAW_MW[mw_idx*8 +: 8];
            SUB_LOOP: sub_data = lb_data_in;
            default: sub_data = tx_data_in;
        endcase
    end

    // generated pattern overrides substitution on its own bits
    logic [7:0] pat_mask;
    logic [7:0] data_nxt;
    assign pat_mask = pdir ? 8'h00 : pmask;
    assign data_nxt = func_en ?
        ((sub_data & ~pat_mask) | (prbs_data_in & pat_mask)) :
        tx_data_in;

    // =========================================================
    // signaling snapshot and trunk conditioning
    // =========================================================
    logic [3:0] snap_r [32];
    logic snap_take;
    assign snap_take = slot_valid_in && mf_gen_in &&
                       frame_num_in == 4'd0;

    genvar si;
    generate
        for (si = 0; si < 32; si++) begin : g_snap
            always_ff @(posedge clk_sys_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    snap_r[si] <= 4'h0;
                end else if (snap_take && slot_num_in == 5'(si)) begin
                    snap_r[si] <= tx_signaling_in;
                end
            end
        end
    endgenerate

    // first frame passes live input; later frames use the lock
    logic snap_on;
    logic [3:0] sig_src;
    logic trunk_on;
    logic [3:0] sig_nxt;
    assign snap_on = payload_cfg_r[PC_SNAP_BIT] && mf_gen_in &&
                     frame_num_in != 4'd0;
    assign sig_src = snap_on ? snap_r[slot_num_in] :
                     tx_signaling_in;
    assign trunk_on = payload_cfg_r[PC_GTRK_BIT] ||
                      sig_ent[ENT_STRK_BIT];
    assign sig_nxt = !func_en ? tx_signaling_in :
                     trunk_on ? sig_ent[3:0] : sig_src;

    // =========================================================
    // output stage
    // =========================================================
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            slot_valid_out <= 1'b0;
            slot_num_out <= 5'd0;
            tx_data_out <= 8'h00;
            tx_signaling_out <= 4'h0;
            prbs_extract_mask_out <= 8'h00;
            prbs_extract_valid_out <= 1'b0;
        end else begin
            slot_valid_out <= slot_valid_in;
            if (slot_valid_in) begin
                slot_num_out <= slot_num_in;
                tx_data_out <= data_nxt;
                tx_signaling_out <= sig_nxt;
                prbs_extract_mask_out <= pmask;
            end
            // detector on transmit side only when direction is 1
            prbs_extract_valid_out <= slot_valid_in && func_en &&
                                      pdir && pmask != 8'h00;
        end
    end

endmodule

// ===== src/indirect_store.sv
`timescale 1ns/10ps
module indirect_store
    import tx_payload_pkg::*;
#(
    parameter int DEPTH = 128
) (
    input wire logic clk_sys_in, // system clock
    input wire logic rstn_in, // async reset, low
    input wire logic wr_en_in, // host write strobe
    input wire logic [6:0] addr_in, // host address
    input wire logic [7:0] wdata_in, // host write data
    output logic [7:0] rdata_out, // host read data
    input wire logic [4:0] slot_in, // stream timeslot
    output logic [7:0] subst_ent_out, // entry 00h+slot
    output logic [7:0] trunk_ent_out, // entry 20h+slot
    output logic [7:0] sig_ent_out // entry 40h+slot
);

    // =========================================================
    // storage
    // =========================================================
    logic [7:0] mem_r [DEPTH];

    // holes and locations past the map read zero, take no write
    function automatic logic valid_addr(input logic [6:0] a);
        valid_addr = (a <= IND_LAST) && (a != IND_SIG_HOLE_A) &&
                     (a != IND_SIG_HOLE_B);
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge clk_sys_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    mem_r[gi] <= 8'h00;
                end else if (wr_en_in && valid_addr(addr_in) &&
                             addr_in == 7'(gi)) begin
                    mem_r[gi] <= wdata_in;
                end
            end
        end
    endgenerate

    logic [6:0] sig_addr;
    assign sig_addr = IND_SIG_BASE | {2'b00, slot_in};
    assign rdata_out = valid_addr(addr_in) ? mem_r[addr_in] : 8'h00;
    assign subst_ent_out = mem_r[{2'b00, slot_in}];
    assign trunk_ent_out = mem_r[IND_TRUNK_BASE | {2'b00, slot_in}];
    assign sig_ent_out = valid_addr(sig_addr) ? mem_r[sig_addr] : 8'h00;

endmodule

// ===== testbench/e1_tx_payload_control_access_monitor.sv
`timescale 1ns/10ps
module e1_tx_payload_control_access_monitor
    import tx_payload_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int ACC_CYCLES = ACCESS_CYCLES
) (
    input wire logic clk_sys_in, // clock
    input wire logic rstn_in, // reset, low
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // write
    input wire logic [ADDR_W-1:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic slot_valid_in, // slot strobe
    input wire logic [3:0] frame_num_in, // frame
    input wire logic [7:0] tx_data_in, // payload in
    input wire logic slot_valid_out, // strobe out
    input wire logic [7:0] tx_data_out, // payload out
    input wire logic pattern_start_out, // start pulse
    input wire logic pattern_direction_out, // direction
    input wire logic [1:0] pattern_framing_mode_out // mode
);
    logic [4:0] cnt_r;
    logic [7:0] tc_r, pc_r, d_r;
    logic en_r;
    logic [2:0] fr_r;
    logic wr_go, go;
    assign wr_go = psel && penable && pwrite;
    assign go = wr_go && paddr == (IDX_TEST_CFG << ADDR_SHIFT)
        && pwdata[0] && !tc_r[0] && en_r;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in)
            cnt_r <= 5'h00;
        else if (wr_go && paddr == (IDX_ACC_CONTROL << ADDR_SHIFT)
            && cnt_r == 5'h00)
            cnt_r <= 5'(ACC_CYCLES + 1);
        else if (cnt_r != 5'h00)
            cnt_r <= cnt_r - 5'h01;
    end
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tc_r <= RST_TEST_CFG;
            pc_r <= RST_PAYLOAD_CFG;
            en_r <= 1'b0;
        end else if (wr_go) begin
            if (paddr == (IDX_TEST_CFG << ADDR_SHIFT))
                tc_r <= pwdata[7:0] & TC_WRITE_MASK;
            if (paddr == (IDX_PAYLOAD_CFG << ADDR_SHIFT))
                pc_r <= pwdata[7:0] & PC_WRITE_MASK;
            if (paddr == (IDX_FUNC_ENABLE << ADDR_SHIFT))
                en_r <= pwdata[0];
        end
    end
    always_ff @(posedge clk_sys_in) begin
        d_r <= tx_data_in;
        fr_r <= frame_num_in[2:0];
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    sequence s_status_rd;
        psel && penable && !pwrite && paddr == (IDX_ACC_STATUS << ADDR_SHIFT);
    endsequence
    sequence s_mw_slot;
        slot_valid_in && en_r && pc_r[2:1] == 2'b01 && tc_r[3:2] == 2'b11;
    endsequence
    AST_READY_ZERO_WAIT: assert property (
        psel && penable |-> pready) else $error("not ready");
    AST_BUSY_FLAG: assert property (
        s_status_rd |-> prdata == {31'h0000_0000, cnt_r != 5'h00})
        else $error("busy flag");
    AST_LAUNCH_PULSE: assert property (
        go |-> ##2 pattern_start_out) else $error("no start pulse");
    AST_LAUNCH_ONLY_RISE: assert property (
        pattern_start_out |-> $past(go, 2)) else $error("stray start");
    AST_PATTERN_CFG: assert property (
        pattern_direction_out == tc_r[1]
        && pattern_framing_mode_out == tc_r[3:2])
        else $error("pattern control");
    AST_STREAM_LATENCY: assert property (
        slot_valid_out == $past(slot_valid_in)) else $error("slot latency");
    AST_DISABLED_PASS: assert property (
        slot_valid_in && !en_r |=> tx_data_out == d_r)
        else $error("payload altered");
    AST_MILLIWATT: assert property (
        s_mw_slot |=> tx_data_out == (pc_r[0] ? ULAW_MW[8*fr_r +: 8]
        : ALAW_MW[8*fr_r +: 8])) else $error("milliwatt");
endmodule

bind e1_tx_payload_control_access e1_tx_payload_control_access_monitor #(
    .ADDR_W(ADDR_W), .ACC_CYCLES(ACC_CYCLES)) i_monitor (.*);

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import tx_payload_pkg::*;
    localparam logic [11:0] A_TC = IDX_TEST_CFG << ADDR_SHIFT;
    localparam logic [11:0] A_ST = IDX_ACC_STATUS << ADDR_SHIFT;
    localparam logic [11:0] A_AC = IDX_ACC_CONTROL << ADDR_SHIFT;
    localparam logic [11:0] A_AD = IDX_ACC_DATA << ADDR_SHIFT;
    localparam logic [11:0] A_PC = IDX_PAYLOAD_CFG << ADDR_SHIFT;
    localparam logic [11:0] A_EN = IDX_FUNC_ENABLE << ADDR_SHIFT;
    logic clk_sys_in = 1'b0, rstn_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic slot_valid_in = 1'b0, mf_gen_in = 1'b0;
    logic [4:0] slot_num_in = '0, slot_num_out;
    logic [3:0] frame_num_in = '0, tx_signaling_in = '0, tx_signaling_out;
    logic [7:0] tx_data_in = '0, lb_data_in = '0, prbs_data_in = '0;
    logic pready, pslverr, slot_valid_out, pattern_start_out, rerr;
    logic pattern_direction_out, prbs_extract_valid_out;
    logic [7:0] tx_data_out, prbs_extract_mask_out, en_m, pc_m, tc_m;
    logic [1:0] pattern_framing_mode_out;
    logic [7:0] ent [128];
    logic [3:0] lat [32];
    int n_fail = 0, checks = 0, n_start = 0, seed = 61496;

    e1_tx_payload_control_access i_e1_tx_payload_control_access (.*);

    always #50 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) if (pattern_start_out === 1'b1) n_start++;

    // ============================================================
    // bus and check helpers
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d);
        int k = 0;
        @(posedge clk_sys_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ind_wait;
        int k = 0;
        do begin
            apb(1'b0, A_ST, 8'h00);
            k++;
        end while (rdat[0] !== 1'b0 && k < 20);
        chk("idle", 32'h0000_0000, rdat);
    endtask
    task automatic ind_wr(input logic [6:0] a, input logic [7:0] d);
        apb(1'b1, A_AD, d);
        apb(1'b1, A_AC, {1'b0, a});
        if (a <= 7'h5f && a != 7'h40 && a != 7'h50) ent[a] = d;
        ind_wait;
    endtask
    task automatic ind_rd(input logic [6:0] a);
        apb(1'b1, A_AC, {1'b1, a});
        apb(1'b0, A_ST, 8'h00);
        chk("busy", 32'h0000_0001, rdat);
        ind_wait;
        apb(1'b0, A_AD, 8'h00);
        chk("entry", {24'h00_0000, ent[a]}, rdat);
    endtask
    // ============================================================
    // expected stream values
    function automatic logic [7:0] sub(input logic [2:0] c, f,
        input logic [4:0] s, input logic [7:0] d, l);
        case (c)
            3'b001: return ent[{2'b01, s}];
            3'b010: return ALAW_MW[8*f +: 8];
            3'b011: return ULAW_MW[8*f +: 8];
            3'b100: return l;
            default: return d;
        endcase
    endfunction
    function automatic logic [7:0] pmask(input logic t);
        case (tc_m[3:2])
            2'b00: return 8'hff;
            2'b01: return t ? 8'hff : 8'h00;
            2'b10: return t ? 8'hfe : 8'h00;
            default: return 8'h00;
        endcase
    endfunction
    task automatic send(input logic [4:0] s, input logic [3:0] f, sg,
        input logic m);
        logic [7:0] d, l, p, v, mk, e;
        logic [3:0] es;
        d = $random(seed);
        l = $random(seed);
        p = $random(seed);
        e = ent[{2'b10, s}];
        @(posedge clk_sys_in);
        slot_valid_in <= 1'b1;
        {slot_num_in, frame_num_in, mf_gen_in} <= {s, f, m};
        {tx_data_in, tx_signaling_in} <= {d, sg};
        {lb_data_in, prbs_data_in} <= {l, p};
        @(posedge clk_sys_in);
        slot_valid_in <= 1'b0;
        @(negedge clk_sys_in);
        mk = pmask(e[6]);
        v = sub(pc_m[2:0] == 3'b000 ? ent[s][7:5] : pc_m[2:0], f[2:0], s,
            d, l);
        if (!tc_m[1]) v = (v & ~mk) | (p & mk);
        es = (pc_m[6] || e[4]) ? e[3:0] :
            (pc_m[7] && m && f != 0) ? lat[s] : sg;
        if (f == 4'h0 && m) lat[s] = sg;
        if (!en_m[0]) {v, es} = {d, sg};
        chk("valid", 32'h0000_0001, slot_valid_out);
        chk("slot", s, slot_num_out);
        chk("data", v, tx_data_out);
        chk("sig", es, tx_signaling_out);
        chk("mask", mk, prbs_extract_mask_out);
        if (en_m[0])
            chk("xv", tc_m[1] && mk != 0, prbs_extract_valid_out);
    endtask

    // ============================================================
    // main sequence
    initial begin
        logic [11:0] ra [6] = '{A_TC, A_ST, A_AC, A_AD, A_PC, A_EN};
        logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
        ent = '{default: 8'h00};
        {en_m, pc_m, tc_m} = {RST_FUNC_ENABLE, RST_PAYLOAD_CFG, RST_TEST_CFG};
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ra[i], 8'h00);
            chk("reset", rv[i], rdat);
        end
        apb(1'b0, 12'h334, 8'h00);
        chk("unmapped", 32'h0000_0001, {rdat, rerr});
        apb(1'b1, A_PC, 8'hff);
        apb(1'b0, A_PC, 8'h00);
        chk("cfg mask", 32'h0000_00c7, rdat);
        for (int a = 0; a < 96; a++) ind_wr(7'(a), 8'($random(seed)));
        apb(1'b1, A_AD, 8'h5a);
        apb(1'b1, A_AC, 8'h03);
        apb(1'b1, A_AC, 8'h04);
        ent[3] = 8'h5a;
        ind_wait;
        for (int i = 0; i < 28; i++)
            ind_rd(i < 4 ? 7'(8'h40 + 8'(i << 4)) : 7'($random(seed)));
        for (int i = 0; i < 24; i++) begin
            en_m = {7'h00, 1'(i % 8 != 7)};
            pc_m = {1'b0, 1'($random(seed)), 3'b000, 3'(i % 6)};
            tc_m = {4'h0, 2'(i / 6), 1'((i / 3) % 2), 1'b0};
            apb(1'b1, A_EN, en_m);
            apb(1'b1, A_PC, pc_m);
            apb(1'b1, A_TC, tc_m);
            repeat (4) send(5'($random(seed)), 4'($random(seed)),
                4'($random(seed)), 1'($random(seed)));
        end
        ind_wr(7'h45, 8'h00);
        {en_m, pc_m, tc_m} = {8'h01, 8'h80, 8'h0c};
        apb(1'b1, A_EN, en_m);
        apb(1'b1, A_PC, pc_m);
        apb(1'b1, A_TC, tc_m);
        send(5'd5, 4'h0, 4'ha, 1'b1);
        send(5'd5, 4'h3, 4'h5, 1'b1);
        send(5'd5, 4'h4, 4'h5, 1'b0);
        n_start = 0;
        apb(1'b1, A_TC, 8'h0d);
        repeat (3) @(posedge clk_sys_in);
        apb(1'b1, A_TC, 8'h0d);
        apb(1'b1, A_TC, 8'h0c);
        apb(1'b1, A_EN, 8'h00);
        apb(1'b1, A_TC, 8'h0d);
        repeat (3) @(posedge clk_sys_in);
        chk("starts", 32'h0000_0001, n_start);
        close_out;
    end
    initial begin
        repeat (30000) @(posedge clk_sys_in);
        n_fail++;
        close_out;
    end
endmodule
